// ### design/sram_host_ctrl.sv
// host controller driving an asynchronous 32k x 8 static memory
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`include "sram_host_regs.svh"
module sram_host_ctrl #(
  parameter int unsigned RD_TOT = `SRAM_RD_TOT,
  parameter int unsigned WP_CYC = `SRAM_WP_CYC,
  parameter int unsigned WREC_CYC = `SRAM_WREC_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`SRAM_ADDR_W-1:0] req_addr,
  input wire logic [`SRAM_DATA_W-1:0] req_wdata,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [`SRAM_DATA_W-1:0] rsp_rdata,
  // memory pins
  output logic sel_n,
  output logic wstrobe_n,
  output logic odrive_n,
  output logic [`SRAM_ADDR_W-1:0] word_select_lines,
  input wire logic [`SRAM_DATA_W-1:0] shared_data_lines_in,
  output logic [`SRAM_DATA_W-1:0] shared_data_lines_out,
  output logic shared_data_lines_oe
);
  // ---------------------------------------------------------------
  // phase timer
  // ---------------------------------------------------------------
  phase_timer_if tmr ();

  sram_phase_timer u_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tmr(tmr)
  );

  function automatic logic [`SRAM_TMR_W-1:0] phase_len(input int unsigned cyc);
    phase_len = `SRAM_TMR_W'(cyc - 1);
  endfunction : phase_len

  // ---------------------------------------------------------------
  // read data synchroniser
  // ---------------------------------------------------------------
  // pins change with no relation to sys_clk, so the read phase is
  // stretched by the two sync stages before the word is taken
  logic [`SRAM_DATA_W-1:0] data_meta;
  logic [`SRAM_DATA_W-1:0] data_sync;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= shared_data_lines_in;
      data_sync <= data_meta;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  sram_host_pkg::host_state_t state;
  sram_host_pkg::host_state_t next_state;
  logic next_sel_n;
  logic next_wstrobe_n;
  logic next_odrive_n;
  logic [`SRAM_ADDR_W-1:0] next_addr;
  logic [`SRAM_DATA_W-1:0] next_dout;
  logic next_oe;
  logic next_rsp_valid;
  logic [`SRAM_DATA_W-1:0] next_rdata;
  logic read_done;

  assign read_done = (state == sram_host_pkg::ST_READ) && tmr.expired;
  // a read can chain straight into another read, a write waits for idle
  assign req_ready = (state == sram_host_pkg::ST_IDLE) || (read_done && !req_write);

  always_comb begin
    next_state = state;
    next_sel_n = sel_n;
    next_wstrobe_n = wstrobe_n;
    next_odrive_n = odrive_n;
    next_addr = word_select_lines;
    next_dout = shared_data_lines_out;
    next_oe = shared_data_lines_oe;
    next_rsp_valid = 1'b0;
    next_rdata = rsp_rdata;
    tmr.load = 1'b0;
    tmr.load_val = '0;
    case (state)
      sram_host_pkg::ST_IDLE: begin
        if (req_valid && req_write) begin
          next_state = sram_host_pkg::ST_WRITE;
          next_sel_n = 1'b0;
          next_wstrobe_n = 1'b0;
          next_odrive_n = 1'b1;
          next_addr = req_addr;
          next_dout = req_wdata;
          next_oe = 1'b1;
          tmr.load = 1'b1;
          tmr.load_val = phase_len(WP_CYC);
        end else if (req_valid) begin
          next_state = sram_host_pkg::ST_READ;
          next_sel_n = 1'b0;
          next_wstrobe_n = 1'b1;
          next_odrive_n = 1'b0;
          next_addr = req_addr;
          next_oe = 1'b0;
          tmr.load = 1'b1;
          tmr.load_val = phase_len(RD_TOT);
        end
      end
      sram_host_pkg::ST_READ: begin
        if (tmr.expired) begin
          next_rsp_valid = 1'b1;
          next_rdata = data_sync;
          if (req_valid && !req_write) begin
            // select and output drive stay low, only the word changes
            next_addr = req_addr;
            tmr.load = 1'b1;
            tmr.load_val = phase_len(RD_TOT);
          end else begin
            next_state = sram_host_pkg::ST_IDLE;
            next_sel_n = 1'b1;
            next_odrive_n = 1'b1;
          end
        end
      end
      sram_host_pkg::ST_WRITE: begin
        if (tmr.expired) begin
          // data held past the strobe rise for a clean hold time
          next_state = sram_host_pkg::ST_WREC;
          next_wstrobe_n = 1'b1;
          tmr.load = 1'b1;
          tmr.load_val = phase_len(WREC_CYC);
        end
      end
      sram_host_pkg::ST_WREC: begin
        if (tmr.expired) begin
          next_state = sram_host_pkg::ST_IDLE;
          next_sel_n = 1'b1;
          next_oe = 1'b0;
        end
      end
      default: begin
        next_state = sram_host_pkg::ST_IDLE;
        next_sel_n = 1'b1;
        next_wstrobe_n = 1'b1;
        next_odrive_n = 1'b1;
        next_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= sram_host_pkg::ST_IDLE;
      sel_n <= 1'b1;
      wstrobe_n <= 1'b1;
      odrive_n <= 1'b1;
      word_select_lines <= '0;
      shared_data_lines_out <= '0;
      shared_data_lines_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      state <= next_state;
      sel_n <= next_sel_n;
      wstrobe_n <= next_wstrobe_n;
      odrive_n <= next_odrive_n;
      word_select_lines <= next_addr;
      shared_data_lines_out <= next_dout;
      shared_data_lines_oe <= next_oe;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // helper counters of phase lengths, read only by the checks
  logic [`SRAM_TMR_W-1:0] rd_len;
  logic [`SRAM_TMR_W-1:0] wp_len;
  logic [`SRAM_TMR_W-1:0] next_rd_len;
  logic [`SRAM_TMR_W-1:0] next_wp_len;

  // rd_len restarts at every timer load, so a chained read is timed
  // exactly like one that starts from idle
  always_comb begin
    next_rd_len = tmr.load ? `SRAM_TMR_W'(1) : rd_len + `SRAM_TMR_W'(1);
    next_wp_len = !wstrobe_n ? wp_len + `SRAM_TMR_W'(1) : '0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_len <= '0;
      wp_len <= '0;
    end else begin
      rd_len <= next_rd_len;
      wp_len <= next_wp_len;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  idle_deselect_a: assert property (
    state == sram_host_pkg::ST_IDLE |-> sel_n && !shared_data_lines_oe && wstrobe_n)
    else $error("idle without deselect");
  write_drive_a: assert property (
    !wstrobe_n |-> !sel_n && shared_data_lines_oe && odrive_n)
    else $error("strobe low without data drive");
  addr_hold_a: assert property (
    !sel_n && $past(!sel_n) && !$past(read_done) |-> $stable(word_select_lines))
    else $error("word select changed mid cycle");
  read_pins_a: assert property (
    state == sram_host_pkg::ST_READ |-> !sel_n && wstrobe_n && !odrive_n)
    else $error("read pins wrong");
  read_float_a: assert property (
    state == sram_host_pkg::ST_READ |-> !shared_data_lines_oe)
    else $error("host drives data during read");
  read_chain_a: assert property (
    read_done && req_valid && !req_write |=> state == sram_host_pkg::ST_READ && !sel_n
      && word_select_lines == $past(req_addr))
    else $error("chained read broken");
  no_contention_a: assert property (
    shared_data_lines_oe |-> odrive_n)
    else $error("both sides may drive data");
  release_first_a: assert property (
    $rose(shared_data_lines_oe) |-> $past(odrive_n) && $past(state) == sram_host_pkg::ST_IDLE)
    else $error("data driven straight after read");
  read_length_a: assert property (
    rsp_valid |-> $past(rd_len) == `SRAM_TMR_W'(RD_TOT))
    else $error("read phase length wrong");
  strobe_width_a: assert property (
    $rose(wstrobe_n) && $past(sel_n) == 1'b0 |-> wp_len == `SRAM_TMR_W'(WP_CYC))
    else $error("strobe width wrong");
endmodule : sram_host_ctrl

// ### design/sram_host_regs.svh
// timing constants for the static memory host controller
`ifndef SRAM_HOST_REGS_SVH
`define SRAM_HOST_REGS_SVH
// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define SRAM_ADDR_W 15
`define SRAM_DATA_W 8
`define SRAM_TMR_W 8
// ---------------------------------------------------------------
// times in ns and derived cycle counts at sys_clk
// ---------------------------------------------------------------
`define SRAM_CLK_NS 5
`define SRAM_T_RC_NS 70
`define SRAM_T_WC_NS 70
`define SRAM_T_WP_NS 55
`define SRAM_SYNC_STAGES 2
`define SRAM_RD_CYC ((`SRAM_T_RC_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`define SRAM_WP_CYC ((`SRAM_T_WP_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`define SRAM_WC_CYC ((`SRAM_T_WC_NS + `SRAM_CLK_NS - 1) / `SRAM_CLK_NS)
`define SRAM_RD_TOT (`SRAM_RD_CYC + `SRAM_SYNC_STAGES + 1)
`define SRAM_WREC_CYC (`SRAM_WC_CYC - `SRAM_WP_CYC)
`endif

// ### design/sram_host_pkg.sv
// types shared by the static memory host controller
package sram_host_pkg;
  // ---------------------------------------------------------------
  // controller states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_WREC = 4'h8
  } host_state_t;
endpackage : sram_host_pkg

// ### design/phase_timer_if.sv
// carrier between the controller and its phase timer
`include "sram_host_regs.svh"
interface phase_timer_if;
  logic load;
  logic [`SRAM_TMR_W-1:0] load_val;
  logic expired;
  modport ctrl (output load, output load_val, input expired);
  modport timer (input load, input load_val, output expired);
endinterface : phase_timer_if

// ### design/sram_phase_timer.sv
// down counter that times each bus phase
`include "sram_host_regs.svh"
module sram_phase_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // controller side
  phase_timer_if.timer tmr
);
  logic [`SRAM_TMR_W-1:0] cnt;
  logic [`SRAM_TMR_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (tmr.load) begin
      next_cnt = tmr.load_val;
    end else if (cnt != '0) begin
      next_cnt = cnt - `SRAM_TMR_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // expired must not look at load: the controller derives load from
  // expired, and a term back would close a combinational loop
  assign tmr.expired = (cnt == '0);
endmodule : sram_phase_timer

// ### verification/sram_mem_model.sv
// level-sensitive model of the 32k x 8 static memory
`include "sram_host_regs.svh"
module sram_mem_model (
  // memory pins
  input wire logic sel_n,
  input wire logic wstrobe_n,
  input wire logic odrive_n,
  input wire logic [`SRAM_ADDR_W-1:0] word_select_lines,
  input wire logic [`SRAM_DATA_W-1:0] bus,
  // data drive
  output logic [`SRAM_DATA_W-1:0] mem_dout,
  output logic mem_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // no clock, no reset: cells stay unknown until first written
  logic [`SRAM_DATA_W-1:0] cells [0:(1 << `SRAM_ADDR_W) - 1];
  // pins settle briefly first: select, strobe and word lines move in
  // separate zero-delay steps, which must not hit the previous word
  always @(sel_n, wstrobe_n, word_select_lines, bus) begin
    #1;
    if (!sel_n && !wstrobe_n) cells[word_select_lines] = bus;
  end
  // deselect, strobe low or drive high all float the lines
  assign mem_oe = !sel_n && wstrobe_n && !odrive_n;
  assign mem_dout = cells[word_select_lines];
endmodule : sram_mem_model

// ### verification/testbench.sv
// self-checking bench for the static memory host controller
`include "sram_host_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned RD = 4;
  localparam int unsigned WP = 2;
  localparam int unsigned WR = 1;
  logic sys_clk, resetn, req_valid, req_write, req_ready, rsp_valid;
  logic [`SRAM_ADDR_W-1:0] req_addr, word_select_lines;
  logic [`SRAM_DATA_W-1:0] req_wdata, rsp_rdata, dout, mem_dout, bus, cnt;
  logic sel_n, wstrobe_n, odrive_n, oe, mem_oe;
  int error_cnt = 0, num_checks = 0, wlow = 0;
  // released lines show a changing pattern, never a stale value
  assign bus = oe ? dout : (mem_oe ? mem_dout : cnt ^ 8'h5a);
  sram_host_ctrl #(.RD_TOT(RD), .WP_CYC(WP), .WREC_CYC(WR)) dut_u (.sys_clk(sys_clk),
    .resetn(resetn), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .sel_n(sel_n), .wstrobe_n(wstrobe_n), .odrive_n(odrive_n),
    .word_select_lines(word_select_lines), .shared_data_lines_in(bus),
    .shared_data_lines_out(dout), .shared_data_lines_oe(oe));
  sram_mem_model mem_u (.sel_n(sel_n), .wstrobe_n(wstrobe_n), .odrive_n(odrive_n),
    .word_select_lines(word_select_lines), .bus(bus), .mem_dout(mem_dout), .mem_oe(mem_oe));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic do_req(input logic w, input logic [14:0] a, input logic [7:0] d);
    int i;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    for (i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      if (req_ready === 1'b1) break;
    end
    @(posedge sys_clk);
  endtask : do_req
  task automatic wait_sig(input logic rsp, output int n);
    n = 0;
    while ((rsp ? rsp_valid : req_ready) !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_sig
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic chk_reset();
    @(negedge sys_clk);
    check("idle pins", {sel_n, wstrobe_n, odrive_n, oe, rsp_valid, req_ready}, 6'h39);
  endtask : chk_reset
  task automatic wr_one(input logic [14:0] a, input logic [7:0] d);
    int n;
    int w0;
    w0 = wlow;
    do_req(1'b1, a, d);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    check("write pins", {sel_n, wstrobe_n, odrive_n, oe}, 4'h3);
    check("write addr", 32'(word_select_lines), 32'(a));
    check("write data", 32'(dout), 32'(d));
    wait_sig(1'b0, n);
    check("write length", n, WP + WR);
    check("strobe width", wlow - w0, WP);
    check("write end", {sel_n, oe}, 2'h2);
  endtask : wr_one
  task automatic rd_one(input logic [14:0] a, input logic [7:0] e);
    int n;
    do_req(1'b0, a, 8'h00);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    check("read pins", {sel_n, wstrobe_n, odrive_n, oe}, 4'h4);
    check("read addr", 32'(word_select_lines), 32'(a));
    wait_sig(1'b1, n);
    check("read latency", n, RD);
    check("read data", 32'(rsp_rdata), 32'(e));
    check("read end", {sel_n, odrive_n}, 2'h3);
  endtask : rd_one
  task automatic rd_chain(input logic [14:0] a1, input logic [7:0] e1,
                          input logic [14:0] a2, input logic [7:0] e2);
    int n;
    do_req(1'b0, a1, 8'h00);
    do_req(1'b0, a2, 8'h00);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    check("chain first", {rsp_valid, rsp_rdata}, {1'b1, e1});
    check("chain pins", {sel_n, odrive_n, word_select_lines}, {2'b00, a2});
    // let the first answer pulse pass before waiting for the second
    @(negedge sys_clk);
    wait_sig(1'b1, n);
    check("chain latency", n, RD - 1);
    check("chain second", 32'(rsp_rdata), 32'(e2));
  endtask : rd_chain
  task automatic wr_after_rd(input logic [14:0] a, input logic [7:0] e,
                             input logic [14:0] b, input logic [7:0] d);
    do_req(1'b0, a, 8'h00);
    do_req(1'b1, b, d);
    req_valid <= 1'b0;
    @(negedge sys_clk);
    check("turnaround", {wstrobe_n, mem_oe, oe, rsp_rdata}, {3'b001, e});
    repeat (WP + WR + 1) @(negedge sys_clk);
    rd_one(b, d);
  endtask : wr_after_rd
  // ---------------------------------------------------------------
  // clock, monitors, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cnt <= resetn ? cnt + 8'h01 : 8'h00;
  always @(negedge sys_clk) begin
    if (wstrobe_n === 1'b0) wlow++;
    if (mem_oe === 1'b1 && oe === 1'b1) check("contention", 1, 0);
  end
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {resetn, req_valid, req_write, req_addr, req_wdata} = '0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    chk_reset();
    wr_one(15'h0000, 8'ha5);
    wr_one(15'h7fff, 8'h5a);
    wr_one(15'h1234, 8'h00);
    rd_one(15'h0000, 8'ha5);
    rd_one(15'h7fff, 8'h5a);
    rd_chain(15'h1234, 8'h00, 15'h0000, 8'ha5);
    wr_after_rd(15'h7fff, 8'h5a, 15'h4321, 8'hff);
    wrap_up();
  end
endmodule : testbench
